// ---- irt_eight_bit_timer.sv ----
// ============================================================
// Overview of operation
// R1: enable drives initial level, loads matching reload
// R2: single-pass stops at zero, toggles, flags timeout
// R3: modulo-N reloads low or high by level
// R4: first modulo-N terminal count raises no interrupt
// R5: later terminal counts toggle, flag, repeat
// R6: reload writes apply only at next load
// R7: software avoids writing reload during load
// R8: software never programs initial count one
// R9: zero count wraps to maximum, continues
// R10: wrap from zero is not a timeout
// R11: software stops first, clears status second
// R12: stop and clear act one tick later
// R13: demodulation needs both reloads all ones
// R14: demodulation starts counting on selected edge
// R15: later edges capture complemented count
// R16: counter decrements one per tick
`timescale 1ns/1ps
`default_nettype none
module irt_eight_bit_timer
    import irt_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire irt_cfg_s cfg,
    input wire logic [DIV_W-1:0] tickDivide,
    input wire logic enableWr,
    input wire logic stopWr,
    input wire logic clearWr,
    input wire logic reloadHighWr,
    input wire logic reloadLowWr,
    input wire logic [7:0] wrData,
    input wire logic demodIn,
    output logic timerToggleOutput,
    output logic [7:0] eightBitCountValue,
    output logic [7:0] captureValue,
    output logic captureStrobe,
    output logic timeoutIrq,
    output irt_stat_s status
);
    // ============================================================
    // state
    // ============================================================
    logic [7:0] reloadHighCount_q;
    logic [7:0] reloadLowCount_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic out_q;
    logic out_d;
    logic running_q;
    logic counting_q;
    logic counting_d;
    logic firstDone_q;
    logic timeout_q;
    logic irq_q;
    logic [7:0] capture_q;
    logic capStb_q;
    logic stopPend_q;
    logic clearPend_q;
    logic demSync1_q;
    logic demSync2_q;
    logic demPrev_q;
    logic tick;

    irt_tick_div #(.DIV_W(DIV_W)) u_div (
        .core_clk(core_clk),
        .nrst(nrst),
        .divide(tickDivide),
        .tick(tick)
    );

    // chooses the reload matching an output level
    function automatic logic [7:0] pickReload(input logic lvl, input logic [7:0] hi, input logic [7:0] lo);
        pickReload = lvl ? hi : lo;
    endfunction : pickReload

    // ============================================================
    // input edge detection, after a two-stage synchroniser
    // ============================================================
    wire logic riseEdge = demSync2_q & ~demPrev_q;
    wire logic fallEdge = ~demSync2_q & demPrev_q;
    wire logic edgeHit = (cfg.edgeSel == IRT_EDGE_RISE) ? riseEdge :
                         (cfg.edgeSel == IRT_EDGE_FALL) ? fallEdge : (riseEdge | fallEdge);

    // ============================================================
    // decode of the counting step
    // ============================================================
    wire logic isDemod = (cfg.mode == IRT_DEMOD);
    wire logic isModulo = (cfg.mode == IRT_MODULO);
    // terminal count is reaching zero from one; the wrap out of zero is not
    wire logic stepNow = running_q & counting_q & tick & ~stopPend_q;
    wire logic terminal = stepNow & (count_q == 8'h01) & ~isDemod;
    wire logic demStart = running_q & isDemod & ~counting_q & edgeHit;
    wire logic demCapture = running_q & isDemod & counting_q & edgeHit;
    wire logic reportTimeout = terminal & (~isModulo | firstDone_q);

    // next count, output and counting state
    always_comb begin
        count_d = count_q;
        out_d = out_q;
        counting_d = counting_q;
        if (enableWr) begin
            // R1: initial level and load
            out_d = cfg.initLevel;
            count_d = pickReload(cfg.initLevel, reloadHighCount_q, reloadLowCount_q);
            counting_d = ~isDemod;
        end else if (demStart) begin
            // R14: start on selected edge
            counting_d = 1'b1;
        end else if (terminal) begin
            out_d = ~out_q;
            if (isModulo) begin
                // R3: reload by new level
                // R6: reload taken only here and at enable
                count_d = pickReload(~out_q, reloadHighCount_q, reloadLowCount_q);
            end else begin
                // R2: single pass halts at zero
                count_d = 8'h00;
                counting_d = 1'b0;
            end
        end else if (stepNow) begin
            // R16: one per tick
            // R9: zero wraps to maximum
            // R10: wrap is no timeout
            count_d = count_q - 8'h01;
        end
    end

    // ============================================================
    // main counter registers
    // ============================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= IRT_COUNT_RST;
            out_q <= 1'b0;
            counting_q <= 1'b0;
        end else begin
            count_q <= count_d;
            out_q <= out_d;
            counting_q <= counting_d;
        end
    end

    // reload registers, writable at any time
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reloadHighCount_q <= IRT_COUNT_RST;
            reloadLowCount_q <= IRT_COUNT_RST;
        end else begin
            if (reloadHighWr) reloadHighCount_q <= wrData;
            if (reloadLowWr) reloadLowCount_q <= wrData;
        end
    end

    // ============================================================
    // run control; stop and clear wait for the next tick
    // ============================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            running_q <= 1'b0;
            stopPend_q <= 1'b0;
            clearPend_q <= 1'b0;
            firstDone_q <= 1'b0;
        end else begin
            // R12: stop lands on tick
            if (enableWr) begin
                running_q <= 1'b1;
                stopPend_q <= 1'b0;
            end else if (stopPend_q && tick) begin
                running_q <= 1'b0;
                stopPend_q <= 1'b0;
            end else if (stopWr) begin
                stopPend_q <= 1'b1;
            end
            if (clearPend_q && tick) begin
                clearPend_q <= 1'b0;
            end else if (clearWr) begin
                clearPend_q <= 1'b1;
            end
            // R4: first modulo terminal silent
            if (enableWr) begin
                firstDone_q <= 1'b0;
            end else if (terminal) begin
                firstDone_q <= 1'b1;
            end
        end
    end

    // ============================================================
    // timeout status and interrupt; a new timeout beats a clear
    // ============================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timeout_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // R5: later timeouts flag
            if (reportTimeout) begin
                timeout_q <= 1'b1;
            end else if (clearPend_q && tick) begin
                timeout_q <= 1'b0;
            end
            // interrupt is a one-cycle pulse, gated by enable
            irq_q <= reportTimeout & cfg.intEnable;
        end
    end

    // ============================================================
    // synchroniser and capture
    // ============================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            demSync1_q <= 1'b0;
            demSync2_q <= 1'b0;
            demPrev_q <= 1'b0;
            capture_q <= IRT_COUNT_RST;
            capStb_q <= 1'b0;
        end else begin
            demSync1_q <= demodIn;
            demSync2_q <= demSync1_q;
            demPrev_q <= demSync2_q;
            capStb_q <= demCapture;
            // R15: store complemented count
            if (demCapture) capture_q <= ~count_q;
        end
    end

    assign timerToggleOutput = out_q;
    assign eightBitCountValue = count_q;
    assign captureValue = capture_q;
    assign captureStrobe = capStb_q;
    assign timeoutIrq = irq_q;
    assign status = '{timeout: timeout_q, running: running_q, counting: counting_q};
endmodule : irt_eight_bit_timer
`default_nettype wire

// ---- irt_pkg.sv ----
package irt_pkg;
    // ============================================================
    // mode and edge encodings
    // ============================================================
    typedef enum logic [1:0] {
        IRT_SINGLE = 2'b00,
        IRT_MODULO = 2'b01,
        IRT_DEMOD = 2'b10
    } irt_mode_e;

    localparam logic [1:0] IRT_EDGE_FALL = 2'h0;
    localparam logic [1:0] IRT_EDGE_RISE = 2'h1;
    localparam logic [1:0] IRT_EDGE_BOTH = 2'h2;

    // reset values and count maximum
    localparam logic [7:0] IRT_COUNT_RST = 8'h00;
    localparam logic [7:0] IRT_COUNT_MAX = 8'hff;
    localparam logic [7:0] IRT_TICK_DIV_RST = 8'h00;

    // ============================================================
    // grouped control and status
    // ============================================================
    typedef struct packed {
        irt_mode_e mode;
        logic initLevel;
        logic intEnable;
        logic [1:0] edgeSel;
    } irt_cfg_s;

    typedef struct packed {
        logic timeout;
        logic running;
        logic counting;
    } irt_stat_s;
endpackage : irt_pkg

// ---- irt_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// counter/timer clock enable divider
// ============================================================
module irt_tick_div
    import irt_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [DIV_W-1:0] divide,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    wire logic wrapNow = (cnt_q >= divide);

    // divide of zero gives a tick every cycle
    assign cnt_d = wrapNow ? '0 : cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
    assign tick = wrapNow;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= IRT_TICK_DIV_RST[DIV_W-1:0];
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : irt_tick_div
`default_nettype wire

// ---- irt_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module irt_checker
    import irt_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire irt_cfg_s cfg,
    input wire logic [DIV_W-1:0] tickDivide,
    input wire logic enableWr,
    input wire logic stopWr,
    input wire logic clearWr,
    input wire logic reloadHighWr,
    input wire logic reloadLowWr,
    input wire logic [7:0] wrData,
    input wire logic demodIn,
    input wire logic timerToggleOutput,
    input wire logic [7:0] eightBitCountValue,
    input wire logic [7:0] captureValue,
    input wire logic captureStrobe,
    input wire logic timeoutIrq,
    input wire irt_stat_s status
);
    logic [7:0] high_q;
    logic [7:0] low_q;

    // shadow reloads; a write in the load cycle still loads the old value
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            high_q <= 8'h00;
            low_q <= 8'h00;
        end else begin
            high_q <= reloadHighWr ? wrData : high_q;
            low_q <= reloadLowWr ? wrData : low_q;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    enable_load_a: assert property (enableWr |=> timerToggleOutput == $past(cfg.initLevel)
        && eightBitCountValue == ($past(cfg.initLevel) ? $past(high_q) : $past(low_q))) else $error("bad load");
    single_halt_a: assert property ($past(cfg.mode) == IRT_SINGLE && $rose(status.timeout) |->
        eightBitCountValue == 8'h00 && !status.counting && timerToggleOutput != $past(timerToggleOutput))
        else $error("bad single end");
    modulo_reload_a: assert property ($past(cfg.mode) == IRT_MODULO && $past(status.counting)
        && !$past(enableWr) && $past(eightBitCountValue) == 8'h01 && $changed(eightBitCountValue)
        |-> timerToggleOutput != $past(timerToggleOutput)
        && eightBitCountValue == (timerToggleOutput ? $past(high_q) : $past(low_q))) else $error("bad reload");
    timeout_irq_a: assert property ($rose(status.timeout) && $past(cfg.intEnable) |-> timeoutIrq)
        else $error("missing irq");
    wrap_quiet_a: assert property ($past(eightBitCountValue) == 8'h00 && eightBitCountValue == 8'hff
        && !$past(enableWr) |-> !$rose(status.timeout) && $stable(timerToggleOutput)) else $error("bad wrap");
    count_step_a: assert property (status.counting && $past(status.counting) && !$past(enableWr)
        && $past(eightBitCountValue) != 8'h01 && $changed(eightBitCountValue)
        |-> eightBitCountValue == $past(eightBitCountValue) - 8'h01) else $error("bad step");
    capture_strobe_a: assert property ($changed(captureValue) |-> captureStrobe) else $error("no strobe");
    stop_tick_a: assert property (stopWr && !enableWr && tickDivide == '0 ##1 !enableWr
        |=> !status.running) else $error("late stop");
endmodule : irt_checker

bind irt_eight_bit_timer irt_checker #(.DIV_W(DIV_W)) u_checker (.core_clk(core_clk), .nrst(nrst), .cfg(cfg),
    .tickDivide(tickDivide), .enableWr(enableWr), .stopWr(stopWr), .clearWr(clearWr),
    .reloadHighWr(reloadHighWr), .reloadLowWr(reloadLowWr), .wrData(wrData), .demodIn(demodIn),
    .timerToggleOutput(timerToggleOutput), .eightBitCountValue(eightBitCountValue),
    .captureValue(captureValue), .captureStrobe(captureStrobe), .timeoutIrq(timeoutIrq), .status(status));
`default_nettype wire

// ---- irt_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import irt_pkg::*;
();
    logic core_clk = 1'b0;
    logic [7:0] tickDivide = 8'h00;
    logic nrst = 1'b0;
    irt_cfg_s cfg = '0;
    logic enableWr = 1'b0;
    logic stopWr = 1'b0;
    logic clearWr = 1'b0;
    logic reloadHighWr = 1'b0;
    logic reloadLowWr = 1'b0;
    logic [7:0] wrData = 8'h00;
    logic demodIn = 1'b0;
    logic timerToggleOutput;
    logic [7:0] eightBitCountValue;
    logic [7:0] captureValue;
    logic captureStrobe;
    logic timeoutIrq;
    irt_stat_s status;
    int failCount = 0;
    int checkCount = 0;
    int cyc = 0;
    logic [8:0] irqQ[$];
    logic [7:0] gapQ[$];
    logic [7:0] prevCap;
    logic capValid = 1'b0;

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // prescale mostly zero so every cycle is a tick
    irt_eight_bit_timer u_dut (.core_clk(core_clk), .nrst(nrst), .cfg(cfg), .tickDivide(tickDivide),
        .enableWr(enableWr), .stopWr(stopWr), .clearWr(clearWr), .reloadHighWr(reloadHighWr),
        .reloadLowWr(reloadLowWr), .wrData(wrData), .demodIn(demodIn), .timerToggleOutput(timerToggleOutput),
        .eightBitCountValue(eightBitCountValue), .captureValue(captureValue), .captureStrobe(captureStrobe),
        .timeoutIrq(timeoutIrq), .status(status));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic completeRun();
        if (failCount == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : completeRun

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : step

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask : pulse

    task automatic load(input logic high, input logic [7:0] v);
        wrData = v;
        if (high) begin
            pulse(reloadHighWr);
        end else begin
            pulse(reloadLowWr);
        end
    endtask : load

    task automatic start(input irt_mode_e m, input logic lvl);
        cfg.mode = m;
        cfg.initLevel = lvl;
        capValid = 1'b0;
        pulse(enableWr);
    endtask : start

    // stop first, clear second, as two writes
    task automatic halt();
        pulse(stopWr);
        pulse(clearWr);
        step(1);
        check("cleared", status.timeout, 1'b0);
    endtask : halt

    // monitor: each interrupt, and each capture but the first of a run, takes the oldest note
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            failCount++;
            completeRun();
        end else begin
            if (timeoutIrq === 1'b1) begin
                check("irq noted", irqQ.size() > 0, 1'b1);
                if (irqQ.size() > 0) begin
                    check("irq state", {timerToggleOutput, eightBitCountValue}, irqQ.pop_front());
                end
            end
            if (captureStrobe === 1'b1) begin
                if (capValid) begin
                    check("gap", 8'(captureValue - prevCap), gapQ.size() > 0 ? gapQ.pop_front() : 8'h00);
                end
                prevCap <= captureValue;
                capValid <= 1'b1;
            end
        end
    end

    initial begin
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] lo2;
        int g;
        int k;
        void'($urandom(32'h427bf68d));
        step(4);
        nrst = 1'b1;
        // single pass, never a count of one
        lo = 8'($urandom_range(40, 2));
        cfg.intEnable = 1'b1;
        load(1'b0, lo);
        irqQ.push_back({1'b1, 8'h00});
        start(IRT_SINGLE, 1'b0);
        check("load", {timerToggleOutput, eightBitCountValue}, {1'b0, lo});
        step(lo - 1);
        check("pre end", {status.timeout, eightBitCountValue}, 9'h001);
        step(4);
        check("single", {status.timeout, timerToggleOutput, status.counting, eightBitCountValue}, 11'h600);
        halt();
        // modulo, low reload rewritten while high phase runs
        hi = 8'($urandom_range(20, 2));
        lo = 8'($urandom_range(20, 2));
        lo2 = 8'($urandom_range(20, 2));
        load(1'b0, lo);
        load(1'b1, hi);
        start(IRT_MODULO, 1'b1);
        load(1'b0, lo2);
        step(hi - 1);
        check("first", {status.timeout, timerToggleOutput, eightBitCountValue}, {2'b00, lo2});
        for (int i = 0; i < 3; i++) begin
            cfg.intEnable = (i != 2);
            if (i != 2) irqQ.push_back(i[0] ? {1'b0, lo2} : {1'b1, hi});
            step(i[0] ? hi : lo2);
            check("phase", {status.timeout, timerToggleOutput, eightBitCountValue}, {1'b1, ~i[0], i[0] ? lo2 : hi});
        end
        pulse(stopWr);
        check("stop late", status.running, 1'b1);
        step(1);
        check("stopped", status.running, 1'b0);
        halt();
        // zero start wraps without a timeout
        cfg.intEnable = 1'b1;
        load(1'b0, 8'h00);
        irqQ.push_back({1'b1, 8'h00});
        start(IRT_SINGLE, 1'b0);
        step(1);
        check("wrap", {status.timeout, timerToggleOutput, eightBitCountValue}, 10'h0ff);
        step(255);
        check("wrap end", {status.timeout, timerToggleOutput, eightBitCountValue}, 10'h300);
        halt();
        // slower tick: each step waits tickDivide+1 cycles, phase unknown
        tickDivide = 8'($urandom_range(3, 1));
        lo = 8'($urandom_range(12, 2));
        load(1'b0, lo);
        irqQ.push_back({1'b1, 8'h00});
        start(IRT_SINGLE, 1'b0);
        k = 0;
        while (status.timeout !== 1'b1 && k < 100) begin
            step(1);
            k++;
        end
        check("slow end", k > (lo - 1) * (tickDivide + 1) && k <= lo * (tickDivide + 1), 1'b1);
        // back to full rate so the clear lands within halt
        tickDivide = 8'h00;
        halt();
        // demodulation with every edge selection
        load(1'b0, 8'hff);
        load(1'b1, 8'hff);
        for (int s = 0; s < 4; s++) begin
            g = $urandom_range(30, 5);
            cfg.edgeSel = 2'(s);
            demodIn = (s == 1);
            step(4);
            start(IRT_DEMOD, 1'b0);
            k = 0;
            for (int t = 1; t <= 6; t++) begin
                demodIn = ~demodIn;
                if (s >= 2 || t[0] == 1'b0) k++;
                if (k >= 3 && (s >= 2 || t[0] == 1'b0)) gapQ.push_back(8'((s >= 2) ? g : 2 * g));
                step(4);
                if (t == 1) check("demod start", status.counting, s >= 2);
                step(g - 4);
            end
            step(6);
            // stopped so the next edge setup cannot capture
            halt();
        end
        check("notes left", irqQ.size() + gapQ.size(), 0);
        completeRun();
    end
endmodule : testbench
`default_nettype wire
